// ---- verilog/lcdm_pkg.sv ----
// Constants and types for the LED display memory and scan sequencer
package lcdm_pkg;
    localparam logic [1:0] PAGE_DIGIT = 2'h0;
    localparam logic [1:0] PAGE_LED = 2'h1;
    localparam logic [1:0] PAGE_DCFG = 2'h2;
    localparam logic [1:0] PAGE_LCFG = 2'h3;
    localparam logic [2:0] OFS_DIGIT_LAST = 3'h5;
    localparam logic [2:0] OFS_CFG_LAST = 3'h3;
    localparam logic [2:0] OFS_GEN_CFG = 3'h0;
    localparam logic [2:0] OFS_KEY1 = 3'h1;
    localparam logic [2:0] OFS_KEY2 = 3'h2;
    localparam logic [7:0] RST_GEN_CFG = 8'hFB;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] MODE_COMMON = 2'h3;
    localparam logic [1:0] MODE_VARIABLE = 2'h0;
    localparam int CMD_ADDR_LSB = 1;
    localparam int CMD_PAGE_LSB = 4;
    localparam int CMD_FIXED_BIT = 6;
    localparam int CMD_READ_BIT = 7;
    localparam logic [7:0] CMD_DISP_ON = 8'h0D;
    localparam logic [7:0] CMD_DISP_OFF = 8'h0E;
    localparam logic [7:0] CMD_DISP_MASK = 8'hBF;
    localparam int CLK_MHZ = 50;
    localparam int STEP_US = 4;
    localparam int STEP_CYC = STEP_US * CLK_MHZ;
    localparam int KEY_SEG_US = 64;
    localparam int KEY_SEG_CYC = KEY_SEG_US * CLK_MHZ;
    localparam int KEY_SAMPLE_US = 60;
    localparam int KEY_SAMPLE_CYC = KEY_SAMPLE_US * CLK_MHZ;
    localparam int LED_SLOT_US = 512;
    localparam int LED_SLOT_CYC = LED_SLOT_US * CLK_MHZ;
    localparam int STEPS = 16;
    typedef enum logic [1:0] {LCDM_KEY, LCDM_LED, LCDM_DIG} lcdm_slot_t;
endpackage

// ---- verilog/lcdm_core.sv ----
// Paged display and config memory with serial port and scan sequencer
`timescale 1ns/1ps
module lcdm_core
    import lcdm_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial link, own clock domain
    input wire logic sclk_i,
    input wire logic stb_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    // Key matrix returns
    input wire logic key1_i,
    input wire logic key2_i,
    // LED drivers
    output logic [7:0] segment_o,
    output logic [5:0] grid_o,
    output logic led_grid_o,
    output logic display_on_o
);
    // Link side: shift register; each finished byte toggles across.
    logic [2:0] l_bitcnt_r;
    logic [7:0] l_shift_r;
    logic [7:0] l_byte_r;
    logic l_first_r;
    // Power-up values: the strobe is the link side's only reset
    logic l_tog_r = 1'b0;
    logic l_isfirst_r;
    logic [7:0] l_tx_r;
    logic [7:0] s_rdbyte_r;
    logic l_rdmode_r = 1'b0;

    // Strobe high restarts framing; partial bytes are dropped.
    always_ff @(posedge sclk_i or posedge stb_n_i) begin
        if (stb_n_i) begin
            l_bitcnt_r <= 3'h0;
            l_first_r <= 1'b1;
        end else begin
            l_bitcnt_r <= l_bitcnt_r + 3'h1;
            if (l_bitcnt_r == 3'h7) begin
                l_first_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sclk_i) begin
        l_shift_r <= {din_i, l_shift_r[7:1]};
        if (l_bitcnt_r == 3'h7 && !stb_n_i) begin
            l_byte_r <= {din_i, l_shift_r[7:1]};
            l_isfirst_r <= l_first_r;
            l_tog_r <= ~l_tog_r;
            if (l_first_r) begin
                l_rdmode_r <= din_i;
            end
        end
    end

    // Read byte from system domain is stable between bytes.
    always_ff @(negedge sclk_i) begin
        if (l_bitcnt_r == 3'h0) begin
            l_tx_r <= s_rdbyte_r;
        end else begin
            l_tx_r <= {1'b0, l_tx_r[7:1]};
        end
    end

    assign dout_o = l_tx_r[0];
    assign dout_oe_o = !stb_n_i && !l_first_r && l_rdmode_r;

    typedef struct packed {
        logic [2:0] tog;
        logic [1:0] k1s;
        logic [1:0] k2s;
        logic [7:0] gen_cfg;
        logic [23:0] dig_cfg;
        logic [31:0] led_cfg;
        logic [47:0] dig_mem;
        logic [7:0] led_mem;
        logic led_written;
        logic disp_on;
        logic fixed;
        logic rd;
        logic [1:0] page;
        logic [2:0] ptr;
        logic [7:0] rdbyte;
        logic [15:0] keys;
        lcdm_slot_t slot;
        logic [2:0] digit;
        logic [2:0] chan;
        logic [3:0] step;
        logic [15:0] cyc;
        logic [7:0] seg;
        logic [5:0] grid;
        logic led_grid;
    } lcdm_state_t;

    lcdm_state_t st_r;
    lcdm_state_t st_nxt;

    // On-time in steps out of sixteen
    function automatic logic [3:0] on_steps(input logic [3:0] code);
        case (code[2:0])
            3'h0: on_steps = 4'h1;
            3'h1: on_steps = 4'h2;
            3'h2: on_steps = 4'h4;
            3'h3: on_steps = 4'hA;
            3'h4: on_steps = 4'hB;
            3'h5: on_steps = 4'hC;
            3'h6: on_steps = 4'hD;
            default: on_steps = 4'hE;
        endcase
    endfunction

    // Active brightness code; reserved modes behave as common
    function automatic logic [3:0] pick_code(input logic [7:0] gcfg,
                                             input logic [3:0] own);
        if (gcfg[4:3] == MODE_VARIABLE) begin
            pick_code = own;
        end else begin
            pick_code = {1'b0, gcfg[7:5]};
        end
    endfunction

    // Pointer lies inside the page; shared by write and read decode
    function automatic logic in_page(input logic [1:0] page,
                                     input logic [2:0] ptr);
        if (page == PAGE_DIGIT) begin
            in_page = ptr <= OFS_DIGIT_LAST;
        end else if (page == PAGE_LED) begin
            in_page = ptr == 3'h0;
        end else begin
            in_page = ptr <= OFS_CFG_LAST;
        end
    endfunction

    // Step 0 is blanking, then on for the coded number of steps
    function automatic logic step_lit(input logic [3:0] step,
                                      input logic [3:0] code);
        step_lit = step != 4'h0 && step <= on_steps(code);
    endfunction

    // Byte returned by a read at the state's page and pointer
    function automatic logic [7:0] mem_byte(input lcdm_state_t s,
                                            input logic [15:0] keys);
        mem_byte = 8'h00;
        if (s.page == PAGE_LED && s.ptr == OFS_KEY1) begin
            mem_byte = keys[7:0];
        end else if (s.page == PAGE_LED && s.ptr == OFS_KEY2) begin
            mem_byte = keys[15:8];
        end else if (!in_page(s.page, s.ptr)) begin
            mem_byte = 8'h00;
        end else if (s.page == PAGE_DIGIT) begin
            mem_byte = s.dig_mem[s.ptr*8 +: 8];
        end else if (s.page == PAGE_LED) begin
            mem_byte = s.led_mem;
        end else if (s.page == PAGE_DCFG && s.ptr == OFS_GEN_CFG) begin
            mem_byte = s.gen_cfg;
        end else if (s.page == PAGE_DCFG) begin
            mem_byte = s.dig_cfg[(s.ptr-3'h1)*8 +: 8];
        end else begin
            mem_byte = s.led_cfg[s.ptr*8 +: 8];
        end
    endfunction

    logic byte_ev;
    logic [7:0] rx;
    logic [3:0] code;
    logic lit;

    assign byte_ev = st_r.tog[2] ^ st_r.tog[1];
    assign rx = l_byte_r;
    assign s_rdbyte_r = st_r.rdbyte;

    always_comb begin
        st_nxt = st_r;
        code = 4'h0;
        lit = 1'b0;
        st_nxt.tog = {st_r.tog[1:0], l_tog_r};
        st_nxt.k1s = {st_r.k1s[0], key1_i};
        st_nxt.k2s = {st_r.k2s[0], key2_i};

        // Byte from host
        if (byte_ev) begin
            if (l_isfirst_r) begin
                st_nxt.ptr = rx[CMD_ADDR_LSB +: 3];
                st_nxt.page = rx[CMD_PAGE_LSB +: 2];
                st_nxt.fixed = rx[CMD_FIXED_BIT];
                st_nxt.rd = rx[CMD_READ_BIT];
                if ((rx & CMD_DISP_MASK) == CMD_DISP_ON) begin
                    st_nxt.disp_on = 1'b1;
                end else if ((rx & CMD_DISP_MASK) == CMD_DISP_OFF) begin
                    st_nxt.disp_on = 1'b0;
                end
            end else begin
                if (!st_r.rd && in_page(st_r.page, st_r.ptr)) begin
                    case (st_r.page)
                        PAGE_DIGIT: if (st_r.ptr <= OFS_DIGIT_LAST) begin
                            st_nxt.dig_mem[st_r.ptr*8 +: 8] = rx;
                        end
                        PAGE_LED: if (st_r.ptr == 3'h0) begin
                            st_nxt.led_mem = rx;
                            st_nxt.led_written = 1'b1;
                        end
                        PAGE_DCFG: if (st_r.ptr == OFS_GEN_CFG) begin
                            st_nxt.gen_cfg = rx;
                        end else if (st_r.ptr <= OFS_CFG_LAST) begin
                            st_nxt.dig_cfg[(st_r.ptr-3'h1)*8 +: 8] = rx;
                        end
                        default: if (st_r.ptr <= OFS_CFG_LAST) begin
                            st_nxt.led_cfg[st_r.ptr*8 +: 8] = rx;
                        end
                    endcase
                end
                if (!st_r.fixed) begin
                    st_nxt.ptr = st_r.ptr + 3'h1;
                end
            end
        end

        // Read data for the next outgoing byte
        st_nxt.rdbyte = mem_byte(st_nxt, st_r.keys);

        // Scan sequencer, runs continuously
        st_nxt.cyc = st_r.cyc + 16'h1;
        st_nxt.seg = 8'h00;
        st_nxt.grid = 6'h00;
        st_nxt.led_grid = 1'b0;
        case (st_r.slot)
            LCDM_KEY: begin
                st_nxt.seg[st_r.chan] = 1'b1;
                if (st_r.cyc == 16'(KEY_SAMPLE_CYC)) begin
                    st_nxt.keys[st_r.chan] = st_r.k1s[1];
                    st_nxt.keys[8 + st_r.chan] = st_r.k2s[1];
                end
                if (st_r.cyc == 16'(KEY_SEG_CYC - 1)) begin
                    st_nxt.cyc = 16'h0;
                    st_nxt.chan = st_r.chan + 3'h1;
                    if (st_r.chan == 3'h7) begin
                        st_nxt.digit = 3'h0;
                        st_nxt.step = 4'h0;
                        if (st_r.led_written && st_r.disp_on) begin
                            st_nxt.slot = LCDM_LED;
                        end else if (st_r.disp_on) begin
                            st_nxt.slot = LCDM_DIG;
                        end
                    end
                end
            end
            LCDM_LED: begin
                // Grid and segments follow the flag in the same cycle
                st_nxt.led_grid = st_nxt.disp_on;
                for (int i = 0; i < 8; i++) begin
                    code = pick_code(st_r.gen_cfg,
                                     st_r.led_cfg[i*4 +: 4]);
                    if (step_lit(st_r.step, code) && st_nxt.disp_on) begin
                        st_nxt.seg[i] = st_r.led_mem[i];
                    end
                end
                if (st_r.cyc == 16'(STEP_CYC - 1)) begin
                    st_nxt.cyc = 16'h0;
                    st_nxt.step = st_r.step + 4'h1;
                    if (st_r.step == 4'(STEPS - 1)) begin
                        st_nxt.slot = LCDM_DIG;
                    end
                end
            end
            default: begin
                if (st_r.digit == 3'h0) begin
                    code = pick_code(st_r.gen_cfg, st_r.dig_cfg[3:0]);
                end else begin
                    code = pick_code(st_r.gen_cfg,
                                     st_r.dig_cfg[st_r.digit*4 +: 4]);
                end
                lit = step_lit(st_r.step, code);
                if (lit && st_nxt.disp_on) begin
                    st_nxt.grid[st_r.digit] = 1'b1;
                    st_nxt.seg = st_r.dig_mem[st_r.digit*8 +: 8];
                end
                if (st_r.cyc == 16'(STEP_CYC - 1)) begin
                    st_nxt.cyc = 16'h0;
                    st_nxt.step = st_r.step + 4'h1;
                    if (st_r.step == 4'(STEPS - 1)) begin
                        st_nxt.digit = st_r.digit + 3'h1;
                        if (st_r.digit >= st_r.gen_cfg[2:0]
                            || st_r.digit == OFS_DIGIT_LAST) begin
                            st_nxt.slot = LCDM_KEY;
                            st_nxt.chan = 3'h0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
            st_r.gen_cfg <= RST_GEN_CFG;
            st_r.slot <= LCDM_KEY;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign segment_o = st_r.seg;
    assign grid_o = st_r.grid;
    assign led_grid_o = st_r.led_grid;
    assign display_on_o = st_r.disp_on;
endmodule

// ---- verif/lcdm_core_chk.sv ----
// Port assertions for the display memory and scan sequencer
`timescale 1ns/1ps
module lcdm_core_chk
    import lcdm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial link
    input wire logic sclk_i,
    input wire logic stb_n_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    // Keys and drivers
    input wire logic key1_i,
    input wire logic key2_i,
    input wire logic [7:0] segment_o,
    input wire logic [5:0] grid_o,
    input wire logic led_grid_o,
    input wire logic display_on_o
);
    // Longest frame: keyscan, LED slot and six digits
    localparam int FRAME_MAX = 8 * KEY_SEG_CYC + 7 * STEPS * STEP_CYC;
    logic [16:0] since_key_r;
    always_ff @(posedge clk_i) begin
        if (!rstn_i || (segment_o == 8'h01 && grid_o == 6'h00))
            since_key_r <= 17'h00000;
        else if (since_key_r != 17'h1FFFF)
            since_key_r <= since_key_r + 17'h00001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    reset_dark_a: assert property ($rose(rstn_i) |->
        !display_on_o && grid_o == 6'h00 && segment_o == 8'h00)
        else $error("outputs not cleared by reset");
    grid_onehot_a: assert property ($onehot0(grid_o))
        else $error("more than one grid on");
    led_apart_a: assert property (led_grid_o |-> grid_o == 6'h00)
        else $error("led grid overlaps a digit grid");
    dark_when_off_a: assert property (!display_on_o |->
        grid_o == 6'h00 && !led_grid_o)
        else $error("grid driven while display off");
    key_strobe_a: assert property (grid_o == 6'h00 && !led_grid_o &&
        segment_o != 8'h00 |-> $onehot(segment_o))
        else $error("keyscan strobes several segments");
    read_drive_a: assert property (dout_oe_o |-> !stb_n_i)
        else $error("read data driven outside a frame");
    idle_link_a: assert property (stb_n_i [*8] |->
        $stable(display_on_o))
        else $error("display flag moved without a command");
    frame_repeat_a: assert property (since_key_r < FRAME_MAX)
        else $error("scan frame did not restart");
endmodule

bind lcdm_core lcdm_core_chk lcdm_core_chk_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .sclk_i(sclk_i), .stb_n_i(stb_n_i), .din_i(din_i),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .key1_i(key1_i),
    .key2_i(key2_i), .segment_o(segment_o), .grid_o(grid_o),
    .led_grid_o(led_grid_o), .display_on_o(display_on_o));

// ---- verif/lcdm_host.sv ----
// Behavioural host on the four-wire serial link
`timescale 1ns/1ps
module lcdm_host (
    // Serial link
    output logic sclk_o,
    output logic stb_n_o,
    output logic din_o,
    input wire logic dout_i
);
    logic [7:0] tx_q [8];
    logic [7:0] rx_q [8];
    initial begin
        sclk_o = 1'b1;
        stb_n_o = 1'b1;
        din_o = 1'b0;
    end
    // LSB first; data moves while the clock is low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 0; b < 8; b++) begin
            sclk_o = 1'b0;
            din_o = tx[b];
            #24;
            sclk_o = 1'b1;
            rx[b] = dout_i;
            #24;
        end
        // Gap lets the byte cross into the system clock
        #200;
    endtask
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [7:0] junk;
        stb_n_o = 1'b0;
        #1000;
        xfer(cmd, junk);
        for (int i = 0; i < n; i++)
            xfer(tx_q[i], rx_q[i]);
        #1000;
        stb_n_o = 1'b1;
        // Released line must not keep its last level
        din_o = ~din_o;
        #1000;
    endtask
endmodule

// ---- verif/lcdm_core_tb_top.sv ----
// Self-checking bench for the display memory and scan sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("wrong value %s exp %h seen %h", n, e, g); \
    end \
end
module lcdm_core_tb_top;
    import lcdm_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic key1 = 1'b0;
    logic sclk, stb_n, din, dout, doe, lgrid, don;
    logic [7:0] seg;
    logic [5:0] grid;
    int error_cnt = 0;
    int samples_checked = 0;
    always #10 clk_i = ~clk_i;
    lcdm_core lcdm_core_i (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
        .stb_n_i(stb_n), .din_i(din), .dout_o(dout), .dout_oe_o(doe),
        .key1_i(key1), .key2_i(1'b0), .segment_o(seg), .grid_o(grid),
        .led_grid_o(lgrid), .display_on_o(don));
    lcdm_host lcdm_host_i (.sclk_o(sclk), .stb_n_o(stb_n), .din_o(din),
        .dout_i(dout));
    function automatic logic [7:0] cmd(input logic rd, input logic fx,
        input logic [1:0] pg, input logic [2:0] ad);
        cmd = 8'h00;
        cmd[CMD_READ_BIT] = rd;
        cmd[CMD_FIXED_BIT] = fx;
        cmd[CMD_PAGE_LSB +: 2] = pg;
        cmd[CMD_ADDR_LSB +: 3] = ad;
    endfunction
    task automatic go(input logic [7:0] c, input int n);
        lcdm_host_i.frame(c, n);
    endtask
    task automatic t_reset();
        `CHK("display flag", 1'b0, don)
        go(cmd(1'b1, 1'b0, PAGE_DCFG, 3'h0), 4);
        `CHK("general cfg", RST_GEN_CFG, lcdm_host_i.rx_q[0])
        for (int i = 1; i < 4; i++)
            `CHK("digit cfg", RST_BYTE, lcdm_host_i.rx_q[i])
        go(cmd(1'b1, 1'b0, PAGE_DIGIT, 3'h0), 6);
        for (int i = 0; i < 6; i++)
            `CHK("digit byte", RST_BYTE, lcdm_host_i.rx_q[i])
    endtask
    task automatic t_pointer();
        for (int i = 0; i < 6; i++)
            lcdm_host_i.tx_q[i] = 8'(8'h11 * (i + 1));
        go(cmd(1'b0, 1'b0, PAGE_DIGIT, 3'h0), 6);
        lcdm_host_i.tx_q[0] = 8'hEE;
        go(cmd(1'b0, 1'b1, PAGE_DIGIT, 3'h6), 1);
        go(cmd(1'b1, 1'b1, PAGE_DIGIT, 3'h2), 3);
        for (int i = 0; i < 3; i++)
            `CHK("fixed read", 8'h33, lcdm_host_i.rx_q[i])
        go(cmd(1'b1, 1'b0, PAGE_DIGIT, 3'h0), 6);
        for (int i = 0; i < 6; i++)
            `CHK("auto read", 8'(8'h11 * (i + 1)), lcdm_host_i.rx_q[i])
        lcdm_host_i.tx_q[0] = 8'h12;
        lcdm_host_i.tx_q[1] = 8'h34;
        go(cmd(1'b0, 1'b1, PAGE_LCFG, 3'h1), 2);
        go(cmd(1'b1, 1'b0, PAGE_LCFG, 3'h0), 4);
        for (int i = 0; i < 4; i++)
            `CHK("led cfg", (i == 1) ? 8'h34 : 8'h00, lcdm_host_i.rx_q[i])
    endtask
    task automatic t_scan(input logic [7:0] cfg, input int on, input logic two);
        int on_cyc = 0;
        logic seen2 = 1'b0;
        logic seenl = 1'b0;
        lcdm_host_i.tx_q[0] = cfg;
        go(cmd(1'b0, 1'b1, PAGE_DCFG, OFS_GEN_CFG), 1);
        for (int t = 0; t < 60000 && grid[0] !== 1'b0; t++) @(negedge clk_i);
        for (int t = 0; t < 60000 && grid[0] !== 1'b1; t++) @(negedge clk_i);
        for (int t = 0; t < 20 * STEP_CYC; t++) begin
            on_cyc += int'(grid[0] === 1'b1 && seg === 8'h11);
            seen2 |= grid[1];
            seenl |= lgrid;
            @(negedge clk_i);
        end
        `CHK("on cycles", on * STEP_CYC, on_cyc)
        `CHK("second grid", two, seen2)
        `CHK("led grid", 1'b0, seenl)
    endtask
    task automatic t_led();
        lcdm_host_i.tx_q[0] = 8'h81;
        go(cmd(1'b0, 1'b1, PAGE_LED, 3'h0), 1);
        for (int t = 0; t < 40000 && lgrid !== 1'b1; t++) @(negedge clk_i);
        `CHK("led slot", 1'b1, lgrid)
        repeat (6 * STEP_CYC + 10) @(negedge clk_i);
        `CHK("led segments", 8'h81, seg)
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        key1 = 1'b1;
        t_reset();
        t_pointer();
        go(CMD_DISP_ON, 0);
        `CHK("display flag", 1'b1, don)
        // Per-digit mode: digit one code 7, common code would give 1
        lcdm_host_i.tx_q[0] = 8'h07;
        go(cmd(1'b0, 1'b1, PAGE_DCFG, 3'h1), 1);
        t_scan(8'h01, 14, 1'b1);
        // Reserved mode behaves as common brightness
        t_scan(8'h70, 10, 1'b0);
        t_led();
        go(cmd(1'b1, 1'b0, PAGE_LED, OFS_KEY1), 2);
        `CHK("key row one", 8'hFF, lcdm_host_i.rx_q[0])
        `CHK("key row two", 8'h00, lcdm_host_i.rx_q[1])
        complete_run();
    end
    initial begin
        #2500000;
        error_cnt++;
        complete_run();
    end
endmodule
